// ### rtcai_pkg.sv
`default_nettype none
package rtcai_pkg;
    // Register offsets on the register port
    localparam logic [3:0] ADDR_CTRL = 4'he;
    localparam logic [3:0] ADDR_FLAG = 4'hf;
    // Control register field positions
    localparam int WEEKLY_EN_BIT = 7;
    localparam int DAILY_EN_BIT = 6;
    localparam int SEL_HI_BIT = 2;
    localparam int SEL_LO_BIT = 0;
    // Status register field positions
    localparam int PER_FLAG_BIT = 2;
    localparam int WEEK_FLAG_BIT = 1;
    localparam int DAY_FLAG_BIT = 0;
    localparam int NUM_FLAGS = 3;
    // Values after reset
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic WEEKLY_EN_RESET = 1'b0;
    localparam logic DAILY_EN_RESET = 1'b0;
    // Periodic select codes
    localparam logic [2:0] SEL_OFF = 3'h0;
    localparam logic [2:0] SEL_FIXED_LOW = 3'h1;
    localparam logic [2:0] SEL_PULSE_2HZ = 3'h2;
    localparam logic [2:0] SEL_PULSE_1HZ = 3'h3;
    localparam logic [2:0] SEL_LVL_SEC = 3'h4;
    localparam logic [2:0] SEL_LVL_MIN = 3'h5;
    localparam logic [2:0] SEL_LVL_HOUR = 3'h6;
    localparam logic [2:0] SEL_LVL_MONTH = 3'h7;
    // BCD counter values that mark period boundaries
    localparam logic [6:0] SEC_ZERO = 7'h00;
    localparam logic [6:0] MIN_ZERO = 7'h00;
    localparam logic [5:0] HOUR_ZERO = 6'h00;
    localparam logic [5:0] DAY_FIRST = 6'h01;
    // Seconds increment lag behind the pulse falling edge
    localparam int CLK_HZ = 10000000;
    localparam int SEC_INC_DELAY_US = 46;
    localparam int SEC_INC_DELAY_CYC = (SEC_INC_DELAY_US * (CLK_HZ / 1000000));
    localparam int DELAY_W = 9;
    localparam logic [DELAY_W-1:0] DELAY_LAST = DELAY_W'(SEC_INC_DELAY_CYC - 1);
    localparam logic [DELAY_W-1:0] DELAY_ZERO = 9'h000;
    typedef enum logic {PULSE_HIGH, PULSE_LOW} rtcai_pulse_type;
    typedef enum logic {INC_IDLE, INC_WAIT} rtcai_inc_type;
endpackage
`default_nettype wire

// ### rtcai_alarm_match.sv
`timescale 1ns/1ps
`default_nettype none
module rtcai_alarm_match #(
    parameter bit USE_DAY = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic minute_tick_i,
    input wire logic enable_i,
    input wire logic [2:0] dow_i,
    input wire logic [6:0] days_i,
    input wire logic [5:0] hour_i,
    input wire logic [5:0] alarm_hour_i,
    input wire logic [6:0] min_i,
    input wire logic [6:0] alarm_min_i,
    output logic hit_o
);
    logic day_ok;
    logic time_ok;
    logic hit_next;
    logic hit_reg;

    generate
        if (USE_DAY) begin : g_day
            // Day-of-week mask: one bit per weekday, any set day matches
            assign day_ok = (dow_i < 3'h7) ? days_i[dow_i] : 1'b0;
        end else begin : g_noday
            assign day_ok = 1'b1;
        end
    endgenerate

    assign time_ok = (hour_i == alarm_hour_i) && (min_i == alarm_min_i);
    assign hit_next = minute_tick_i && enable_i && day_ok && time_ok;
    assign hit_o = hit_reg;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= hit_next;
        end
    end
endmodule
`default_nettype wire

// ### rtcai_core.sv
`timescale 1ns/1ps
`default_nettype none
module rtcai_core (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic tick_4hz_i,
    input wire logic tick_2hz_i,
    input wire logic tick_1hz_i,
    input wire logic sec_write_i,
    output logic div_clear_o,
    output logic sec_inc_o,
    input wire logic [6:0] sec_i,
    input wire logic [6:0] min_i,
    input wire logic [5:0] hour_i,
    input wire logic [5:0] day_i,
    input wire logic [2:0] dow_i,
    input wire logic [6:0] alarm_w_days_i,
    input wire logic [5:0] alarm_w_hour_i,
    input wire logic [6:0] alarm_w_min_i,
    input wire logic [5:0] alarm_d_hour_i,
    input wire logic [6:0] alarm_d_min_i,
    output logic irq_out_n_o,
    output logic irq_out_n_oe_n_o
);
    // Control register state
    logic weekly_alarm_enable_reg;
    logic daily_alarm_enable_reg;
    logic [2:0] sel_reg;
    logic weekly_alarm_enable_next;
    logic daily_alarm_enable_next;
    logic [2:0] sel_next;
    logic periodic_select_bit2;
    logic periodic_select_bit1;
    logic periodic_select_bit0;
    // Flags, index by status bit position
    logic [rtcai_pkg::NUM_FLAGS-1:0] flag_reg;
    logic [rtcai_pkg::NUM_FLAGS-1:0] flag_set;
    logic [rtcai_pkg::NUM_FLAGS-1:0] flag_clr;
    logic periodic_flag;
    logic weekly_alarm_flag;
    logic daily_alarm_flag;
    // Register port decode
    logic wr_ctrl;
    logic wr_flag;
    logic [7:0] rd_mux;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    // Mode decode
    logic mode_pulse;
    logic mode_level;
    logic mode_fixed;
    // Pulse generator
    rtcai_pkg::rtcai_pulse_type pulse_reg;
    rtcai_pkg::rtcai_pulse_type pulse_next;
    logic pulse_fall;
    logic pulse_rise;
    // Seconds increment delay
    rtcai_pkg::rtcai_inc_type inc_reg;
    rtcai_pkg::rtcai_inc_type inc_next;
    logic [rtcai_pkg::DELAY_W-1:0] dly_reg;
    logic [rtcai_pkg::DELAY_W-1:0] dly_next;
    logic inc_fire;
    logic inc_reg_pulse;
    logic inc_seen_reg;
    // Level-mode boundary detection
    logic at_sec_zero;
    logic at_min_zero;
    logic at_hour_zero;
    logic at_day_first;
    logic level_event;
    // Minute change tracking
    logic [6:0] min_prev_reg;
    logic min_valid_reg;
    logic minute_tick;
    logic weekly_hit;
    logic daily_hit;
    // Output
    logic irq_assert;
    logic oe_n_reg;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == rtcai_pkg::ADDR_CTRL);
    assign wr_flag = reg_wr_i && (reg_addr_i == rtcai_pkg::ADDR_FLAG);

    assign weekly_alarm_enable_next = wr_ctrl ? reg_wdata_i[rtcai_pkg::WEEKLY_EN_BIT]
                                              : weekly_alarm_enable_reg;
    assign daily_alarm_enable_next = wr_ctrl ? reg_wdata_i[rtcai_pkg::DAILY_EN_BIT]
                                             : daily_alarm_enable_reg;
    assign sel_next = wr_ctrl ? reg_wdata_i[rtcai_pkg::SEL_HI_BIT:rtcai_pkg::SEL_LO_BIT]
                              : sel_reg;
    assign periodic_select_bit2 = sel_reg[2];
    assign periodic_select_bit1 = sel_reg[1];
    assign periodic_select_bit0 = sel_reg[0];

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            weekly_alarm_enable_reg <= rtcai_pkg::WEEKLY_EN_RESET;
            daily_alarm_enable_reg <= rtcai_pkg::DAILY_EN_RESET;
            sel_reg <= rtcai_pkg::SEL_RESET;
        end else begin
            weekly_alarm_enable_reg <= weekly_alarm_enable_next;
            daily_alarm_enable_reg <= daily_alarm_enable_next;
            sel_reg <= sel_next;
        end
    end

    assign mode_fixed = (sel_reg == rtcai_pkg::SEL_FIXED_LOW);
    assign mode_pulse = ~periodic_select_bit2 & periodic_select_bit1;
    assign mode_level = periodic_select_bit2;

    // Pulse generator: rise and fall points come straight from the divider
    // ticks, so any adjustment the divider applies moves them as well.
    // 2 Hz falls each half second, 1 Hz each second, rise at half period
    always_comb begin
        pulse_fall = 1'b0;
        pulse_rise = 1'b0;
        if (sel_reg == rtcai_pkg::SEL_PULSE_2HZ) begin
            pulse_fall = tick_2hz_i;
            pulse_rise = tick_4hz_i & ~tick_2hz_i;
        end else if (sel_reg == rtcai_pkg::SEL_PULSE_1HZ) begin
            pulse_fall = tick_1hz_i;
            pulse_rise = tick_2hz_i & ~tick_1hz_i;
        end
    end

    // low time follows adjusted divider ticks
    always_comb begin
        pulse_next = pulse_reg;
        case (pulse_reg)
            rtcai_pkg::PULSE_HIGH: begin
                if (pulse_fall || (sec_write_i && mode_pulse)) begin
                    pulse_next = rtcai_pkg::PULSE_LOW;
                end
            end
            rtcai_pkg::PULSE_LOW: begin
                if (!mode_pulse || (pulse_rise && !sec_write_i)) begin
                    pulse_next = rtcai_pkg::PULSE_HIGH;
                end
            end
            default: begin
                pulse_next = rtcai_pkg::PULSE_HIGH;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pulse_reg <= rtcai_pkg::PULSE_HIGH;
        end else begin
            pulse_reg <= pulse_next;
        end
    end

    // Seconds increment lags the one-second tick; a seconds write restarts
    // the divider, so a pending increment is dropped to avoid a double count.
    // delayed seconds increment
    always_comb begin
        inc_next = inc_reg;
        dly_next = dly_reg;
        inc_fire = 1'b0;
        case (inc_reg)
            rtcai_pkg::INC_IDLE: begin
                if (tick_1hz_i && !sec_write_i) begin
                    inc_next = rtcai_pkg::INC_WAIT;
                    dly_next = rtcai_pkg::DELAY_ZERO;
                end
            end
            rtcai_pkg::INC_WAIT: begin
                if (sec_write_i) begin
                    inc_next = rtcai_pkg::INC_IDLE;
                end else if (dly_reg == rtcai_pkg::DELAY_LAST) begin
                    inc_next = rtcai_pkg::INC_IDLE;
                    inc_fire = 1'b1;
                end else begin
                    dly_next = dly_reg + 9'h001;
                end
            end
            default: begin
                inc_next = rtcai_pkg::INC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            inc_reg <= rtcai_pkg::INC_IDLE;
            dly_reg <= rtcai_pkg::DELAY_ZERO;
            inc_reg_pulse <= 1'b0;
            inc_seen_reg <= 1'b0;
        end else begin
            inc_reg <= inc_next;
            dly_reg <= dly_next;
            inc_reg_pulse <= inc_fire;
            inc_seen_reg <= inc_reg_pulse;
        end
    end

    assign sec_inc_o = inc_reg_pulse;
    assign div_clear_o = sec_write_i;

    // Counters are compared one cycle after the increment, once they hold
    // the new second.
    assign at_sec_zero = (sec_i == rtcai_pkg::SEC_ZERO);
    assign at_min_zero = (min_i == rtcai_pkg::MIN_ZERO);
    assign at_hour_zero = (hour_i == rtcai_pkg::HOUR_ZERO);
    assign at_day_first = (day_i == rtcai_pkg::DAY_FIRST);

    always_comb begin
        level_event = 1'b0;
        case (sel_reg)
            rtcai_pkg::SEL_LVL_SEC: level_event = inc_seen_reg;
            rtcai_pkg::SEL_LVL_MIN: level_event = inc_seen_reg & at_sec_zero;
            rtcai_pkg::SEL_LVL_HOUR: level_event = inc_seen_reg & at_sec_zero & at_min_zero;
            rtcai_pkg::SEL_LVL_MONTH: level_event = inc_seen_reg & at_sec_zero & at_min_zero
                                                    & at_hour_zero & at_day_first;
            default: level_event = 1'b0;
        endcase
    end

    // Minute change detector; first cycle after reset only loads history
    assign minute_tick = min_valid_reg && (min_i != min_prev_reg);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            min_prev_reg <= 7'h00;
            min_valid_reg <= 1'b0;
        end else begin
            min_prev_reg <= min_i;
            min_valid_reg <= 1'b1;
        end
    end

    rtcai_alarm_match #(
        .USE_DAY(1'b1)
    ) u_weekly (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .minute_tick_i(minute_tick),
        .enable_i(weekly_alarm_enable_reg),
        .dow_i(dow_i),
        .days_i(alarm_w_days_i),
        .hour_i(hour_i),
        .alarm_hour_i(alarm_w_hour_i),
        .min_i(min_i),
        .alarm_min_i(alarm_w_min_i),
        .hit_o(weekly_hit)
    );

    rtcai_alarm_match #(
        .USE_DAY(1'b0)
    ) u_daily (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .minute_tick_i(minute_tick),
        .enable_i(daily_alarm_enable_reg),
        .dow_i(dow_i),
        .days_i(7'h00),
        .hour_i(hour_i),
        .alarm_hour_i(alarm_d_hour_i),
        .min_i(min_i),
        .alarm_min_i(alarm_d_min_i),
        .hit_o(daily_hit)
    );

    // enabling alone never fires, only a minute change does
    assign flag_set[rtcai_pkg::WEEK_FLAG_BIT] = weekly_hit;
    assign flag_set[rtcai_pkg::DAY_FLAG_BIT] = daily_hit;
    assign flag_set[rtcai_pkg::PER_FLAG_BIT] = level_event;

    // flag cleared by writing zero; set wins over a same-cycle clear.
    genvar gi;
    generate
        for (gi = 0; gi < rtcai_pkg::NUM_FLAGS; gi = gi + 1) begin : g_flag
            assign flag_clr[gi] = wr_flag & ~reg_wdata_i[gi];
            always_ff @(posedge sys_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    flag_reg[gi] <= rtcai_pkg::FLAGS_RESET[gi];
                end else if (flag_set[gi]) begin
                    flag_reg[gi] <= 1'b1;
                end else if (flag_clr[gi]) begin
                    flag_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign periodic_flag = flag_reg[rtcai_pkg::PER_FLAG_BIT];
    assign weekly_alarm_flag = flag_reg[rtcai_pkg::WEEK_FLAG_BIT];
    assign daily_alarm_flag = flag_reg[rtcai_pkg::DAY_FLAG_BIT];

    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr_i == rtcai_pkg::ADDR_CTRL) begin
            rd_mux[rtcai_pkg::WEEKLY_EN_BIT] = weekly_alarm_enable_reg;
            rd_mux[rtcai_pkg::DAILY_EN_BIT] = daily_alarm_enable_reg;
            rd_mux[rtcai_pkg::SEL_HI_BIT:rtcai_pkg::SEL_LO_BIT] = sel_reg;
        end else if (reg_addr_i == rtcai_pkg::ADDR_FLAG) begin
            rd_mux[rtcai_pkg::PER_FLAG_BIT] = periodic_flag;
            rd_mux[rtcai_pkg::WEEK_FLAG_BIT] = weekly_alarm_flag;
            rd_mux[rtcai_pkg::DAY_FLAG_BIT] = daily_alarm_flag;
        end
    end
    assign rdata_next = reg_rd_i ? rd_mux : rdata_reg;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
    assign reg_rdata_o = rdata_reg;
    // level flag rises with the increment, so the edge tracks it
    // either alarm flag, fixed low, a low pulse, or the periodic flag in a level mode pulls the line low
    assign irq_assert = weekly_alarm_flag
                      | daily_alarm_flag
                      | (periodic_flag & mode_level)
                      | mode_fixed
                      | ((pulse_reg == rtcai_pkg::PULSE_LOW) & mode_pulse);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= ~irq_assert;
        end
    end

    // open drain, drive zero or release
    assign irq_out_n_o = 1'b0;
    assign irq_out_n_oe_n_o = oe_n_reg;
endmodule
`default_nettype wire

// ### rtcai_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rtcai_core_checker (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic tick_2hz_i,
    input wire logic tick_1hz_i,
    input wire logic sec_write_i,
    input wire logic div_clear_o,
    input wire logic sec_inc_o,
    input wire logic irq_out_n_o,
    input wire logic irq_out_n_oe_n_o
);
    logic [2:0] sel_reg;
    logic [1:0] en_reg;
    logic wr_reg;
    wire ctrl_wr = reg_wr_i && reg_addr_i == rtcai_pkg::ADDR_CTRL;
    wire p2 = sel_reg == rtcai_pkg::SEL_PULSE_2HZ;
    wire p1 = sel_reg == rtcai_pkg::SEL_PULSE_1HZ;
    wire pulse_tick = (p2 && tick_2hz_i) || (p1 && tick_1hz_i);
    // Shadow of the control byte so checks know the mode
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_reg <= 3'h0;
            en_reg <= 2'h0;
            wr_reg <= 1'b0;
        end else begin
            wr_reg <= reg_wr_i;
            if (ctrl_wr) begin
                sel_reg <= reg_wdata_i[2:0];
                en_reg <= reg_wdata_i[7:6];
            end
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_open_drain_low: assert property (irq_out_n_o == 1'b0)
        else $error("open drain data not low");
    a_div_clear_copy: assert property (sec_write_i |-> div_clear_o)
        else $error("divider clear missing");
    a_sec_inc_lag: assert property (tick_1hz_i && !sec_write_i |-> ##[461:461] sec_inc_o)
        else $error("seconds increment lag wrong after tick");
    a_fixed_low: assert property (ctrl_wr && reg_wdata_i[2:0] == 3'h1 |-> ##[1:2] !irq_out_n_oe_n_o)
        else $error("fixed low code did not pull pin");
    a_pulse_fall: assert property (pulse_tick |-> ##2 !irq_out_n_oe_n_o)
        else $error("pulse did not fall after tick");
    a_secwrite_pulse: assert property ((p1 || p2) && sec_write_i |-> ##2 !irq_out_n_oe_n_o)
        else $error("seconds write did not pull pin");
    a_level_fall: assert property (sel_reg == 3'h4 && sec_inc_o |-> ##3 !irq_out_n_oe_n_o)
        else $error("level event not aligned to increment");
    a_level_hold: assert property (sel_reg[2] && !wr_reg && !reg_wr_i && !irq_out_n_oe_n_o
        |=> !irq_out_n_oe_n_o)
        else $error("level interrupt released without clear");
    a_read_unmapped: assert property (reg_rd_i && reg_addr_i < 4'he |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == 4'he
        |=> reg_rdata_o == {en_reg, 3'h0, sel_reg})
        else $error("control readback wrong");
    a_status_upper: assert property (reg_rd_i && reg_addr_i == 4'hf |=> reg_rdata_o[7:3] == 5'h00)
        else $error("status upper bits not zero");
    c_level: cover property (sel_reg[2] && sec_inc_o);
    c_pulse: cover property (pulse_tick);
    c_alarm: cover property (reg_rd_i && reg_addr_i == 4'hf ##1 reg_rdata_o[1]);
endmodule
bind rtcai_core rtcai_core_checker i_rtcai_core_checker (.sys_clk_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tick_2hz_i, .tick_1hz_i, .sec_write_i,
    .div_clear_o, .sec_inc_o, .irq_out_n_o, .irq_out_n_oe_n_o);
`default_nettype wire

// ### rtcai_host_irq.sv
`timescale 1ns/1ps
`default_nettype none
module rtcai_host_irq (
    input wire logic irq_out_n_i,
    input wire logic irq_out_n_oe_n_i,
    output logic irq_line_o
);
    // pull-up line
    // Released pin rises through the pull-up; any driver wins low
    assign irq_line_o = irq_out_n_oe_n_i ? 1'b1 : irq_out_n_i;
endmodule
`default_nettype wire

// ### rtcai_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module rtcai_core_bench;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic tick_4hz_i = 1'b0;
    logic tick_2hz_i = 1'b0;
    logic tick_1hz_i = 1'b0;
    logic sec_write_i = 1'b0;
    logic [6:0] sec_i = 7'h00;
    logic [6:0] min_i = 7'h00;
    logic [5:0] hour_i = 6'h00;
    logic [5:0] day_i = 6'h01;
    logic [2:0] dow_i = 3'h3;
    logic [6:0] alarm_w_days_i = 7'h08;
    logic [5:0] alarm_w_hour_i = 6'h12;
    logic [6:0] alarm_w_min_i = 7'h30;
    logic [5:0] alarm_d_hour_i = 6'h12;
    logic [6:0] alarm_d_min_i = 7'h30;
    logic [7:0] reg_rdata_o;
    logic div_clear_o;
    logic sec_inc_o;
    logic irq_out_n_o;
    logic irq_out_n_oe_n_o;
    logic irq_line;
    int err_count = 0;
    int check_count = 0;
    rtcai_core i_rtcai_core (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .tick_4hz_i, .tick_2hz_i, .tick_1hz_i, .sec_write_i,
        .div_clear_o, .sec_inc_o, .sec_i, .min_i, .hour_i, .day_i, .dow_i, .alarm_w_days_i,
        .alarm_w_hour_i, .alarm_w_min_i, .alarm_d_hour_i, .alarm_d_min_i, .irq_out_n_o,
        .irq_out_n_oe_n_o);
    rtcai_host_irq i_rtcai_host_irq (.irq_out_n_i(irq_out_n_o),
        .irq_out_n_oe_n_i(irq_out_n_oe_n_o), .irq_line_o(irq_line));
    always #50 sys_clk_i = ~sys_clk_i;
    task automatic step(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            #1;
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        step(1);
        reg_wr_i = 1'b0;
        step(1);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] ex);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        step(1);
        reg_rd_i = 1'b0;
        `CHK("read data", ex, reg_rdata_o)
        step(1);
    endtask
    task automatic tick(input logic [2:0] t);
        {tick_1hz_i, tick_2hz_i, tick_4hz_i} = t;
        step(1);
        {tick_1hz_i, tick_2hz_i, tick_4hz_i} = 3'h0;
    endtask
    // Bounded wait so a missing increment cannot hang the run
    task automatic wait_inc(output int n);
        n = 1;
        while (sec_inc_o !== 1'b1 && n < 600) begin
            step(1);
            n++;
        end
        if (n >= 600) begin
            err_count++;
            $display("mismatch increment expected pulse seen none");
            conclude();
        end
    endtask
    task automatic level_case(input logic [2:0] code, input logic ev);
        int n;
        wr(rtcai_pkg::ADDR_CTRL, {5'h00, code});
        tick(3'h7);
        wait_inc(n);
        step(3);
        `CHK("level pin", !ev, irq_line)
        rd_chk(rtcai_pkg::ADDR_FLAG, {5'h00, ev, 2'h0});
        step(5);
        `CHK("level hold", !ev, irq_line)
        wr(rtcai_pkg::ADDR_FLAG, 8'hfb);
        `CHK("level release", 1'b1, irq_line)
    endtask
    task automatic min_bump();
        min_i = 7'h31;
        step(2);
        min_i = 7'h30;
        step(5);
    endtask
    task automatic pulse_case();
        int n;
        wr(rtcai_pkg::ADDR_CTRL, 8'h03);
        tick(3'h7);
        step(1);
        `CHK("pulse 1hz fall", 1'b0, irq_line)
        wait_inc(n);
        `CHK("increment lag", rtcai_pkg::SEC_INC_DELAY_CYC, n)
        tick(3'h3);
        step(1);
        `CHK("pulse 1hz rise", 1'b1, irq_line)
        rd_chk(rtcai_pkg::ADDR_FLAG, 8'h00);
        wr(rtcai_pkg::ADDR_CTRL, 8'h02);
        tick(3'h3);
        step(1);
        `CHK("pulse 2hz fall", 1'b0, irq_line)
        tick(3'h1);
        step(1);
        `CHK("pulse 2hz rise", 1'b1, irq_line)
        sec_write_i = 1'b1;
        #1;
        `CHK("divider clear", 1'b1, div_clear_o)
        step(1);
        sec_write_i = 1'b0;
        step(2);
        `CHK("seconds write pin", 1'b0, irq_line)
    endtask
    task automatic reset_case();
        rd_chk(rtcai_pkg::ADDR_CTRL, 8'h00);
        rd_chk(rtcai_pkg::ADDR_FLAG, 8'h00);
        `CHK("idle pin", 1'b1, irq_line)
        rd_chk(4'h3, 8'h00);
        wr(rtcai_pkg::ADDR_CTRL, 8'h01);
        `CHK("fixed low pin", 1'b0, irq_line)
        wr(rtcai_pkg::ADDR_CTRL, 8'h00);
        step(1);
        `CHK("off pin", 1'b1, irq_line)
    endtask
    task automatic level_miss_case();
        sec_i = 7'h01;
        level_case(3'h5, 1'b0);
        sec_i = 7'h00;
        min_i = 7'h01;
        level_case(3'h6, 1'b0);
        min_i = 7'h00;
        day_i = 6'h02;
        level_case(3'h7, 1'b0);
        wr(rtcai_pkg::ADDR_CTRL, 8'h00);
    endtask
    task automatic alarm_case();
        hour_i = 6'h12;
        min_i = 7'h30;
        wr(rtcai_pkg::ADDR_CTRL, 8'h80);
        step(5);
        `CHK("enable at match", 1'b1, irq_line)
        min_bump();
        `CHK("weekly pin", 1'b0, irq_line)
        rd_chk(rtcai_pkg::ADDR_FLAG, 8'h02);
        wr(rtcai_pkg::ADDR_FLAG, 8'hff);
        rd_chk(rtcai_pkg::ADDR_FLAG, 8'h02);
        wr(rtcai_pkg::ADDR_FLAG, 8'hfd);
        step(3);
        `CHK("weekly cleared", 1'b1, irq_line)
        rd_chk(rtcai_pkg::ADDR_CTRL, 8'h80);
        min_bump();
        rd_chk(rtcai_pkg::ADDR_FLAG, 8'h02);
        wr(rtcai_pkg::ADDR_FLAG, 8'hfd);
        alarm_w_days_i = 7'h01;
        wr(rtcai_pkg::ADDR_CTRL, 8'hc0);
        min_bump();
        rd_chk(rtcai_pkg::ADDR_FLAG, 8'h01);
        alarm_w_days_i = 7'h08;
        min_bump();
        rd_chk(rtcai_pkg::ADDR_FLAG, 8'h03);
        wr(rtcai_pkg::ADDR_FLAG, 8'hfd);
        step(2);
        `CHK("combined pin", 1'b0, irq_line)
        wr(rtcai_pkg::ADDR_FLAG, 8'hfe);
        step(2);
        `CHK("all cleared", 1'b1, irq_line)
        wr(rtcai_pkg::ADDR_CTRL, 8'h00);
        min_bump();
        `CHK("disabled pin", 1'b1, irq_line)
        rd_chk(rtcai_pkg::ADDR_FLAG, 8'h00);
    endtask
    initial begin
        step(3);
        nrst_i = 1'b1;
        step(1);
        reset_case();
        pulse_case();
        for (int c = 4; c < 8; c++) begin
            level_case(c[2:0], 1'b1);
        end
        level_miss_case();
        alarm_case();
        conclude();
    end
endmodule
`default_nettype wire
